// [bench/flash_host.sv]
// host model: frames commands on the serial link, msb first
`default_nettype none
module flash_host (
   // system clock
   input wire logic clk_sys,
   // serial link
   output logic cs_n,
   output logic sclk,
   output logic sdi,
   input wire logic sdo
);
   timeunit 1ns;
   timeprecision 1ns;
   // ************
   // framing
   // ************
   initial begin
      cs_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
   end
   // n bits from bit 47 down; rd keeps the last 8 bits seen on sdo
   task automatic xfer(input logic [47:0] d, input int n, output logic [7:0] rd);
      repeat (2) @(negedge clk_sys);
      cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         sdi = d[47 - i];
         repeat (4) @(negedge clk_sys);
         sclk = 1'b1;
         repeat (4) @(negedge clk_sys);
         rd = {rd[6:0], sdo};
         sclk = 1'b0;
      end
      repeat (4) @(negedge clk_sys);
      cs_n = 1'b1;
      sdi = ~sdi;
      repeat (8) @(negedge clk_sys);
   endtask
endmodule // flash_host
`default_nettype wire

// [bench/prot_checker.sv]
// port assertions for the flash protect and setup block
`default_nettype none
module prot_checker #(parameter BUSY_CYCLES = 16) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic srst,
   // mode and state
   input wire logic quad_lane_active_serial,
   input wire logic four_byte_addr,
   input wire logic [3:0] fast_read_dummy,
   input wire logic [15:0] boot_setup_word,
   input wire logic write_enable_latch,
   input wire logic write_in_progress,
   input wire logic program_start,
   input wire logic command_rejected
);
   timeunit 1ns;
   timeprecision 1ns;
   // ************
   // checks
   // ************
   default clocking @(posedge clk_sys); endclocking
   default disable iff (srst);
   int busy_cnt = 0;
   wire logic [3:0] fld = boot_setup_word[7:4];
   // counts busy cycles so the busy length can be checked at its end
   always @(posedge clk_sys) busy_cnt <= (srst || !write_in_progress) ? 0 : busy_cnt + 1;
   addr_mode_a: assert property ($stable(boot_setup_word) [*2] |-> four_byte_addr == !boot_setup_word[8])
      else $error("address mode wrong");
   dummy_map_a: assert property ($stable({boot_setup_word, quad_lane_active_serial}) [*2] |->
      fast_read_dummy == ((fld == 4'h0 || fld == 4'hF) ? (quad_lane_active_serial ? 4'hA : 4'h8) : fld))
      else $error("dummy count wrong");
   fixed_bits_a: assert property ((boot_setup_word & 16'hFE0F) == 16'hFE0F)
      else $error("fixed setup bits wrong");
   setup_write_a: assert property (!$stable(boot_setup_word) |-> program_start)
      else $error("setup word changed without an accepted write");
   start_busy_a: assert property (program_start |-> write_in_progress && !$past(write_in_progress))
      else $error("busy not raised at start");
   busy_len_a: assert property ($fell(write_in_progress) |-> busy_cnt == BUSY_CYCLES)
      else $error("busy length wrong");
   wel_clear_a: assert property ($fell(write_in_progress) |-> !write_enable_latch)
      else $error("latch not cleared at completion");
   reject_idle_a: assert property (command_rejected && !write_in_progress |-> !program_start ##1 !write_in_progress)
      else $error("refused command executed");
   busy_block_a: assert property (write_in_progress |=> !program_start)
      else $error("start while busy");
   wel_need_a: assert property (program_start |-> $past(write_enable_latch))
      else $error("start without latch");
   cover property (program_start);
   cover property (command_rejected);
   cover property ($fell(write_in_progress));
endmodule // prot_checker
bind flash_prot_nvcfg prot_checker #(.BUSY_CYCLES(BUSY_CYCLES)) u_chk (.clk_sys, .srst, .quad_lane_active_serial,
   .four_byte_addr, .fast_read_dummy, .boot_setup_word, .write_enable_latch, .write_in_progress, .program_start,
   .command_rejected);
`default_nettype wire

// [bench/serial_flash_protect_and_nvcfg_test.sv]
// self-checking bench for the flash protect and setup block
`default_nettype none
`include "flash_prot_consts.vh"
module serial_flash_protect_and_nvcfg_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 1'b0;
   logic srst = 1'b1;
   logic quad = 1'b0;
   wire logic cs_n, sclk, sdi, sdo, four_byte_addr, write_enable_latch, write_in_progress, program_start;
   wire logic command_rejected, oe;
   wire logic [3:0] fast_read_dummy;
   wire logic [15:0] boot_setup_word;
   wire logic [4:0] program_sector;
   int miscompares = 0, n_checks = 0, n_start = 0, n_rej = 0, n_oe = 0, cycles = 0, n, r, s;
   logic [7:0] st;
   logic [4:0] sec;
   logic [15:0] w;
   logic hit;
   logic [3:0] flds [4] = '{4'h0, 4'h1, 4'hE, 4'hF};
   always #50 clk_sys = ~clk_sys;
   flash_prot_nvcfg #(.BUSY_CYCLES(200)) u_dut (.clk_sys, .srst, .cs_n, .sclk, .sdi, .sdo, .sdo_oe(oe),
      .quad_lane_active_serial(quad), .four_byte_addr, .fast_read_dummy, .boot_setup_word, .write_enable_latch,
      .write_in_progress, .program_sector, .program_start, .command_rejected);
   flash_host u_host (.clk_sys, .cs_n, .sclk, .sdi, .sdo);
   // ************
   // tests
   // ************
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      n_start <= n_start + 32'(program_start);
      n_rej <= n_rej + 32'(command_rejected);
      n_oe <= n_oe + 32'(oe);
      if (cycles == 95000) begin
         miscompares = miscompares + 1;
         conclude();
      end
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // status read; sdo must be driven during the frame and released after it
   task automatic rstat();
      int b;
      b = n_oe;
      u_host.xfer({`OP_READ_STATUS, 40'h0}, 16, st);
      chk(16'(n_oe > b), 16'h0001);
      chk(16'(oe), 16'h0000);
   endtask
   task automatic wait_idle();
      for (int k = 0; k < 20; k++) begin
         rstat();
         if (st[0] === 1'b0) break;
      end
   endtask
   // optional write enable, one command frame, then one start or one refusal
   task automatic op(input logic [47:0] d, input int nb, input logic we, input logic ok);
      if (we) u_host.xfer({`OP_WRITE_ENABLE, 40'h0}, 8, st);
      s = n_start;
      r = n_rej;
      u_host.xfer(d, nb, st);
      rstat();
      chk(16'(st[0]), 16'(ok));
      wait_idle();
      chk(16'(n_start - s), 16'(ok));
      chk(16'(n_rej - r), 16'(!ok));
      chk(16'(st[1:0]), 16'({we & ~ok, 1'b0}));
   endtask
   function automatic int span(input int c);
      return (c % 8 == 0) ? 0 : (c % 8 >= 6) ? 32 : 1 << (c % 8 - 1);
   endfunction
   initial begin
      repeat (6) @(negedge clk_sys);
      srst = 1'b0;
      repeat (4) @(negedge clk_sys);
      rstat();
      chk(16'(st), 16'h0000);
      chk(16'(fast_read_dummy), 16'h0008);
      $display("test reset done");
      op({`OP_WRITE_SETUP, 16'hFE8F, 24'h0}, 24, 1'b0, 1'b0);
      chk(boot_setup_word, 16'hFFFF);
      u_host.xfer({`OP_WRITE_ENABLE, 40'h0}, 8, st);
      rstat();
      chk(16'(st), 16'h0002);
      u_host.xfer({`OP_WRITE_DISABLE, 40'h0}, 8, st);
      rstat();
      chk(16'(st), 16'h0000);
      $display("test latch done");
      for (int i = 0; i < 8; i++) begin
         w = {7'h7F, 1'(i / 4), flds[i % 4], 4'hF};
         quad = i[0];
         op({`OP_WRITE_SETUP, w, 24'h0}, 24, 1'b1, 1'b1);
         chk(boot_setup_word, w);
         chk(16'(four_byte_addr), 16'(i < 4));
         chk(16'(fast_read_dummy), 16'((i % 4 == 1 || i % 4 == 2) ? flds[i % 4] : (quad ? 10 : 8)));
      end
      $display("test setup done");
      op({`OP_SECTOR_ERASE, 24'h0, 16'h0}, 31, 1'b1, 1'b0);
      op({`OP_WRITE_BYTES, 24'h050000, 8'hA5, 8'h00}, 40, 1'b1, 1'b1);
      chk(16'(program_sector), 16'h0005);
      op({`OP_QUAD_WRITE, 24'h030000, 8'h5A, 8'h00}, 40, 1'b1, 1'b1);
      chk(16'(program_sector), 16'h0003);
      u_host.xfer({`OP_WRITE_ENABLE, 40'h0}, 8, st);
      s = n_start;
      r = n_rej;
      u_host.xfer({`OP_BULK_ERASE, 40'h0}, 8, st);
      u_host.xfer({`OP_BULK_ERASE, 40'h0}, 8, st);
      wait_idle();
      chk(16'(n_start - s), 16'h0001);
      chk(16'(n_rej - r), 16'h0001);
      $display("test busy done");
      for (int c = 0; c < 16; c++) begin
         op({`OP_WRITE_STATUS, 2'b00, 4'(c), 2'b00, 32'h0}, 16, 1'b1, 1'b1);
         rstat();
         chk(16'(st[7:2]), 16'(c));
         n = span(c);
         for (int k = 0; k < 2; k++) begin
            sec = 5'(c[3] ? n - 1 + k : 32 - n - k);
            hit = c[3] ? sec < n : sec >= 32 - n;
            op({`OP_SECTOR_ERASE, 3'b000, sec, 32'h0}, 32, 1'b1, !hit);
            if (!hit) chk(16'(program_sector), 16'(sec));
         end
         if (c < 8) op({`OP_BULK_ERASE, 40'h0}, 8, 1'b1, c == 0);
      end
      $display("test protect done");
      conclude();
   end
endmodule // serial_flash_protect_and_nvcfg_test
`default_nettype wire

// [hw/flash_prot_nvcfg.v]
// serial flash command logic: status flags, write protection and setup word
`include "flash_prot_consts.vh"
`default_nettype none
module flash_prot_nvcfg #(
   parameter BUSY_CYCLES = 16
) (
   // clock and reset
   input wire clk_sys,
   input wire srst,
   // serial link pins
   input wire cs_n,
   input wire sclk,
   input wire sdi,
   output reg sdo,
   output reg sdo_oe,
   // configuration mode of the attached host
   input wire quad_lane_active_serial,
   // decoded state
   output reg four_byte_addr,
   output reg [3:0] fast_read_dummy,
   output reg [15:0] boot_setup_word,
   output reg write_enable_latch,
   output reg write_in_progress,
   output reg [4:0] program_sector,
   output reg program_start,
   output reg command_rejected
);
   // ****************************************
   // input synchronisers
   // ****************************************
   reg [2:0] cs_sync_reg;
   reg [2:0] clk_sync_reg;
   reg [2:0] dat_sync_reg;
   reg cs_n_reg;
   reg sclk_reg;
   always @(posedge clk_sys) begin
      if (srst) begin
         cs_sync_reg <= 3'h7;
         clk_sync_reg <= 3'h0;
         dat_sync_reg <= 3'h0;
         cs_n_reg <= 1'b1;
         sclk_reg <= 1'b0;
      end else begin
         cs_sync_reg <= {cs_sync_reg[1:0], cs_n};
         clk_sync_reg <= {clk_sync_reg[1:0], sclk};
         dat_sync_reg <= {dat_sync_reg[1:0], sdi};
         if (cs_sync_reg[1] == cs_sync_reg[2])
            cs_n_reg <= cs_sync_reg[2];
         if (clk_sync_reg[1] == clk_sync_reg[2])
            sclk_reg <= clk_sync_reg[2];
      end
   end
   wire clk_agree = (clk_sync_reg[1] == clk_sync_reg[2]);
   wire sclk_rise = clk_agree && clk_sync_reg[2] && !sclk_reg && !cs_n_reg;
   wire sclk_fall = clk_agree && !clk_sync_reg[2] && sclk_reg && !cs_n_reg;
   wire cs_agree = (cs_sync_reg[1] == cs_sync_reg[2]);
   wire cs_rise = cs_agree && cs_sync_reg[2] && !cs_n_reg;
   wire cs_fall = cs_agree && !cs_sync_reg[2] && cs_n_reg;

   // ****************************************
   // protect decode
   // ****************************************
   function prot_hit;
      input [4:0] sector;
      input [2:0] level;
      input top_bot;
      reg [4:0] span;
      begin
         span = 5'h0;
         case (level)
            3'h1: span = 5'h1;
            3'h2: span = 5'h2;
            3'h3: span = 5'h4;
            3'h4: span = 5'h8;
            3'h5: span = 5'h10;
            default: span = 5'h0;
         endcase
         if (level[2] && level[1])
            prot_hit = 1'b1;
         else if (level == 3'h0)
            prot_hit = 1'b0;
         else if (top_bot)
            prot_hit = (sector < span);
         else
            prot_hit = (sector > (5'h1F - span));
      end
   endfunction

   // ****************************************
   // command shifter
   // ****************************************
   localparam ST_IDLE = 2'h0;
   localparam ST_OPCODE = 2'h1;
   localparam ST_BODY = 2'h2;
   reg [1:0] state_reg;
   reg [7:0] shift_reg;
   reg [7:0] opcode_reg;
   reg [2:0] bit_cnt_reg;
   reg [5:0] byte_cnt_reg;
   reg [31:0] addr_reg;
   reg [15:0] data_reg;
   reg [7:0] status_shift_reg;
   reg [7:0] status_byte_reg;
   reg [2:0] protect_level_reg;
   reg protect_level_bit3_reg;
   reg top_bottom_select_reg;
   reg [15:0] busy_cnt_reg;
   reg rejected_reg;
   wire [7:0] shift_next = {shift_reg[6:0], dat_sync_reg[2]};
   wire [2:0] addr_bytes = four_byte_addr ? 3'h4 : 3'h3;
   // sector erase takes the address alone, writes need at least one data byte too
   wire [5:0] addr_need = {3'h0, addr_bytes} + ((opcode_reg == `OP_SECTOR_ERASE) ? 6'h00 : 6'h01);
   wire [4:0] sector_sel = four_byte_addr ? addr_reg[`SECTOR_MSB:`SECTOR_LSB] : addr_reg[`SECTOR_MSB:`SECTOR_LSB];
   wire byte_aligned = (bit_cnt_reg == 3'h0);
   wire is_program = (opcode_reg == `OP_WRITE_BYTES) || (opcode_reg == `OP_DUAL_WRITE) ||
      (opcode_reg == `OP_QUAD_WRITE) || (opcode_reg == `OP_SECTOR_ERASE) ||
      (opcode_reg == `OP_BULK_ERASE) || (opcode_reg == `OP_WRITE_STATUS) ||
      (opcode_reg == `OP_WRITE_SETUP);
   wire needs_addr = (opcode_reg == `OP_WRITE_BYTES) || (opcode_reg == `OP_DUAL_WRITE) ||
      (opcode_reg == `OP_QUAD_WRITE) || (opcode_reg == `OP_SECTOR_ERASE);
   wire any_prot = (protect_level_reg != 3'h0) || protect_level_bit3_reg;
   wire [3:0] dummy_field = boot_setup_word[`SETUP_DUMMY_MSB:`SETUP_DUMMY_LSB];

   always @(posedge clk_sys) begin
      status_byte_reg <= {1'b0, protect_level_bit3_reg, top_bottom_select_reg, protect_level_reg,
         write_enable_latch, write_in_progress};
   end

   always @(posedge clk_sys) begin
      if (srst) begin
         state_reg <= ST_IDLE;
         shift_reg <= 8'h00;
         opcode_reg <= 8'h00;
         bit_cnt_reg <= 3'h0;
         byte_cnt_reg <= 6'h00;
         addr_reg <= 32'h00000000;
         data_reg <= 16'h0000;
         status_shift_reg <= 8'h00;
         protect_level_reg <= 3'h0;
         protect_level_bit3_reg <= 1'b0;
         top_bottom_select_reg <= 1'b0;
         boot_setup_word <= `SETUP_RESET;
         write_enable_latch <= 1'b0;
         write_in_progress <= 1'b0;
         busy_cnt_reg <= 16'h0000;
         rejected_reg <= 1'b0;
         program_sector <= 5'h00;
         program_start <= 1'b0;
         command_rejected <= 1'b0;
         sdo <= 1'b0;
         sdo_oe <= 1'b0;
      end else begin
         program_start <= 1'b0;
         command_rejected <= 1'b0;
         // busy countdown, completion clears the latch
         if (write_in_progress) begin
            if (busy_cnt_reg == 16'h0001) begin
               write_in_progress <= 1'b0;
               write_enable_latch <= 1'b0;
            end
            busy_cnt_reg <= busy_cnt_reg - 16'h0001;
         end
         if (cs_fall) begin
            state_reg <= ST_OPCODE;
            bit_cnt_reg <= 3'h0;
            byte_cnt_reg <= 6'h00;
            rejected_reg <= 1'b0;
         end else if (cs_rise) begin
            state_reg <= ST_IDLE;
            sdo_oe <= 1'b0;
            if (state_reg == ST_BODY && is_program) begin
               if (!byte_aligned || rejected_reg)
                  command_rejected <= 1'b1;
               else if (write_in_progress)
                  command_rejected <= 1'b1;
               else if (!write_enable_latch)
                  command_rejected <= 1'b1;
               else if (opcode_reg == `OP_BULK_ERASE && any_prot)
                  command_rejected <= 1'b1;
               else if (needs_addr && (byte_cnt_reg < addr_need))
                  command_rejected <= 1'b1;
               else if (needs_addr && prot_hit(sector_sel, protect_level_reg, top_bottom_select_reg) |
                  (needs_addr && protect_level_bit3_reg))
                  command_rejected <= 1'b1;
               else if (opcode_reg == `OP_WRITE_SETUP && byte_cnt_reg != 6'h02)
                  command_rejected <= 1'b1;
               else begin
                  if (opcode_reg == `OP_WRITE_SETUP)
                     boot_setup_word <= data_reg | `SETUP_FIXED_MASK;
                  if (opcode_reg == `OP_WRITE_STATUS) begin
                     protect_level_reg <= data_reg[`ST_TB_BIT-1:`ST_PROT_LSB];
                     top_bottom_select_reg <= data_reg[`ST_TB_BIT];
                     protect_level_bit3_reg <= data_reg[`ST_PROT_BIT3];
                  end
                  program_sector <= sector_sel;
                  program_start <= 1'b1;
                  write_in_progress <= 1'b1;
                  busy_cnt_reg <= BUSY_CYCLES[15:0];
               end
            end
         end else if (sclk_rise) begin
            shift_reg <= shift_next;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == 3'h7) begin
               if (state_reg == ST_OPCODE) begin
                  opcode_reg <= shift_next;
                  state_reg <= ST_BODY;
                  if (shift_next == `OP_WRITE_ENABLE && !write_in_progress)
                     write_enable_latch <= 1'b1;
                  if (shift_next == `OP_WRITE_DISABLE && !write_in_progress)
                     write_enable_latch <= 1'b0;
                  if (shift_next == `OP_READ_STATUS)
                     status_shift_reg <= status_byte_reg;
               end else if (state_reg == ST_BODY) begin
                  if (byte_cnt_reg != 6'h3F)
                     byte_cnt_reg <= byte_cnt_reg + 6'h01;
                  if (needs_addr && byte_cnt_reg[2:0] < addr_bytes && byte_cnt_reg < 6'h04)
                     addr_reg <= {addr_reg[23:0], shift_next};
                  else
                     data_reg <= {data_reg[7:0], shift_next};
                  if (opcode_reg == `OP_WRITE_SETUP && byte_cnt_reg >= 6'h02)
                     rejected_reg <= 1'b1;
               end
            end
         end else if (sclk_fall && state_reg == ST_BODY && opcode_reg == `OP_READ_STATUS) begin
            sdo_oe <= 1'b1;
            // a fresh status byte starts at each byte boundary, msb first
            if (bit_cnt_reg == 3'h0) begin
               sdo <= status_byte_reg[7];
               status_shift_reg <= {status_byte_reg[6:0], 1'b0};
            end else begin
               sdo <= status_shift_reg[7];
               status_shift_reg <= {status_shift_reg[6:0], 1'b0};
            end
         end
      end
   end

   // ****************************************
   // setup word decode
   // ****************************************
   always @(posedge clk_sys) begin
      if (srst) begin
         four_byte_addr <= 1'b0;
         fast_read_dummy <= `DUMMY_DEFAULT_X1;
      end else begin
         four_byte_addr <= ~boot_setup_word[`SETUP_ADDR_MODE_BIT];
         if (dummy_field == 4'h0 || dummy_field == 4'hF)
            fast_read_dummy <= quad_lane_active_serial ? `DUMMY_DEFAULT_X4 : `DUMMY_DEFAULT_X1;
         else
            fast_read_dummy <= dummy_field;
      end
   end
endmodule // flash_prot_nvcfg
`default_nettype wire

// [inc/flash_prot_consts.vh]
// constants for the serial flash protect and configuration block
`ifndef FLASH_PROT_CONSTS_VH
`define FLASH_PROT_CONSTS_VH
// opcodes, msb first
`define OP_WRITE_ENABLE 8'h06
`define OP_WRITE_DISABLE 8'h04
`define OP_READ_STATUS 8'h05
`define OP_WRITE_STATUS 8'h01
`define OP_WRITE_BYTES 8'h02
`define OP_DUAL_WRITE 8'hD2
`define OP_QUAD_WRITE 8'h12
`define OP_BULK_ERASE 8'hC7
`define OP_SECTOR_ERASE 8'hD8
`define OP_WRITE_SETUP 8'hB1
// status byte fields
`define ST_BUSY_BIT 0
`define ST_WEL_BIT 1
`define ST_PROT_LSB 2
`define ST_TB_BIT 5
`define ST_PROT_BIT3 6
// setup word fields and reset value
`define SETUP_ADDR_MODE_BIT 8
`define SETUP_DUMMY_MSB 7
`define SETUP_DUMMY_LSB 4
`define SETUP_RESET 16'hFFFF
`define SETUP_FIXED_MASK 16'hFE0F
// default dummy counts
`define DUMMY_DEFAULT_X1 4'h8
`define DUMMY_DEFAULT_X4 4'hA
// sector address bits for the 32-sector density (64 KiB sectors)
`define SECTOR_MSB 20
`define SECTOR_LSB 16
`endif
